// >>> abc_pkg.sv
// constants, types and field arithmetic for the block cipher module
//
// Overview of operation
// - one 128-bit block per operation, 128-bit key, encrypt or decrypt
// - result appears in state memory exactly 375 cycles after the start
// - completion raises the interrupt request only when it is enabled
// - completion fires a one-cycle DMA trigger pulse
// - auto-start begins an operation once the last state byte is written
// - XOR load mode combines each state write with the byte held there
`default_nettype none

package abc_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_KEY = 8'h0c;

    // control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_DEC = 1;
    localparam int CTRL_AUTO = 2;
    localparam int CTRL_XOR = 3;
    localparam int CTRL_IRQEN = 4;
    // status fields
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;

    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int OP_CYCLES = 375;
    localparam logic [8:0] OP_LAST = 9'(OP_CYCLES - 1);
    localparam int NUM_ROUNDS = 10;
    localparam logic [3:0] ROUND_LAST = 4'(NUM_ROUNDS - 1);

    // ---------------------------------------------------------------
    // cipher constants
    // ---------------------------------------------------------------
    localparam logic [7:0] RCON_INIT = 8'h01;
    localparam logic [7:0] GF_POLY = 8'h1b;
    localparam logic [7:0] SBOX_AFF_C = 8'h63;
    localparam logic [7:0] SBOX_INV_C = 8'h05;

    typedef enum logic [2:0] {S_IDLE, S_PREP, S_WHITE, S_ROUND, S_HOLD} abc_state_t;

    // ---------------------------------------------------------------
    // field arithmetic
    // ---------------------------------------------------------------
    function automatic logic [7:0] abc_xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] abc_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = abc_xt(x);
        end
        return p;
    endfunction

endpackage

`default_nettype wire

// >>> abc_sbox.sv
// byte substitution, forward or inverse, by field inversion and affine map
`default_nettype none

module abc_sbox
    import abc_pkg::*;
(
    // data
    input wire logic [7:0] din,
    input wire logic inv,
    output logic [7:0] dout
);

    always_comb begin
        logic [7:0] a;
        logic [7:0] x3;
        logic [7:0] x7;
        logic [7:0] x15;
        logic [7:0] x31;
        logic [7:0] x63;
        logic [7:0] x127;
        logic [7:0] y;
        // inverse affine first when decrypting
        a = inv ? ({din[6:0], din[7]} ^ {din[4:0], din[7:5]} ^ {din[1:0], din[7:2]}
                   ^ SBOX_INV_C) : din;
        // a^254 is the field inverse, zero maps to zero
        x3 = abc_mul(abc_mul(a, a), a);
        x7 = abc_mul(abc_mul(x3, x3), a);
        x15 = abc_mul(abc_mul(x7, x7), a);
        x31 = abc_mul(abc_mul(x15, x15), a);
        x63 = abc_mul(abc_mul(x31, x31), a);
        x127 = abc_mul(abc_mul(x63, x63), a);
        y = abc_mul(x127, x127);
        dout = inv ? y : (y ^ {y[6:0], y[7]} ^ {y[5:0], y[7:6]} ^ {y[4:0], y[7:5]}
                          ^ {y[3:0], y[7:4]} ^ SBOX_AFF_C);
    end

endmodule

`default_nettype wire

// >>> abc_mixcol.sv
// column mixing, forward or inverse, for one four-byte column
`default_nettype none

module abc_mixcol
    import abc_pkg::*;
(
    // data
    input wire logic [3:0][7:0] col,
    input wire logic inv,
    output logic [3:0][7:0] res
);

    always_comb begin
        logic [3:0][7:0] m;
        m = inv ? {8'h09, 8'h0d, 8'h0b, 8'h0e} : {8'h01, 8'h01, 8'h03, 8'h02};
        for (int r = 0; r < 4; r++) begin
            res[r] = 8'h00;
            for (int k = 0; k < 4; k++) begin
                res[r] = res[r] ^ abc_mul(col[(r + k) % 4], m[k]);
            end
        end
    end

endmodule

`default_nettype wire

// >>> abc_top.sv
// block cipher module with AHB-Lite register access and byte-wide memories
`default_nettype none

module abc_top
    import abc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // completion signals
    output logic IRQ,
    output logic DMA_TRIG
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [15:0][7:0] st_q, st_d, key_q, key_d, wst_q, wst_d, wkey_q, wkey_d;
    logic [15:0][7:0] sub, kstep, rres;
    logic [3:0][7:0] ksrc, ksub;
    logic [3:0] sidx_q, sidx_d, kidx_q, kidx_d, rnd_q, rnd_d;
    logic [8:0] cyc_q, cyc_d, span_q, span_d;
    logic [7:0] rcon_q, rcon_d, rcon_prev, rc;
    logic dec_q, dec_d, auto_q, auto_d, xor_q, xor_d, irqen_q, irqen_d;
    logic done_q, done_d, opdec_q, opdec_d, start, finish, busy, kfwd, inv, last;
    abc_state_t fsm_q, fsm_d;
    logic rd_pend_q, rd_pend_d, wr_pend_q, wr_pend_d, hready_d, take, map_hit;
    logic [7:0] addr_q, addr_d;
    logic [31:0] hrdata_d;

    assign busy = (fsm_q != S_IDLE);
    assign inv = opdec_q;
    assign kfwd = !opdec_q || (fsm_q == S_PREP);
    assign last = (rnd_q == ROUND_LAST);
    assign rcon_prev = rcon_q[0] ? {1'b1, rcon_q[7:1] ^ GF_POLY[7:1]} : {1'b0, rcon_q[7:1]};
    assign rc = kfwd ? rcon_q : rcon_prev;
    assign take = HSEL && HTRANS[1] && HREADY;
    assign map_hit = (addr_q[7:4] == 4'h0);

    // ---------------------------------------------------------------
    // round datapath
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_byte
            localparam int R = gi % 4;
            localparam int C = gi / 4;
            localparam int SF = 4 * ((C + R) % 4) + R;
            localparam int SI = 4 * ((C + 4 - R) % 4) + R;
            // row shift folded into the substitution input
            abc_sbox u_sbox (
                .din(inv ? wst_q[SI] : wst_q[SF]),
                .inv(inv),
                .dout(sub[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_col
            logic [3:0][7:0] mc_in, mc_out;
            assign mc_in = inv ? (sub[4*gi+3:4*gi] ^ kstep[4*gi+3:4*gi]) : sub[4*gi+3:4*gi];
            abc_mixcol u_mix (
                .col(mc_in),
                .inv(inv),
                .res(mc_out)
            );
            // encrypt adds the next key after mixing, decrypt before
            assign rres[4*gi+3:4*gi] = inv ? (last ? mc_in : mc_out)
                : ((last ? sub[4*gi+3:4*gi] : mc_out) ^ kstep[4*gi+3:4*gi]);
            assign ksrc[gi] = kfwd ? wkey_q[12+gi] : (wkey_q[12+gi] ^ wkey_q[8+gi]);
            abc_sbox u_ksbox (
                .din(ksrc[(gi + 1) % 4]),
                .inv(1'b0),
                .dout(ksub[gi])
            );
        end
    endgenerate

    // key schedule, one step forward or backward
    always_comb begin
        logic [3:0][7:0] t;
        for (int j = 0; j < 4; j++) begin
            t[j] = ksub[j] ^ ((j == 0) ? rc : 8'h00);
        end
        kstep = wkey_q;
        for (int j = 0; j < 4; j++) begin
            kstep[j] = wkey_q[j] ^ t[j];
        end
        // forward chains on the new words, backward on the old ones
        for (int i = 4; i < 16; i++) begin
            kstep[i] = wkey_q[i] ^ (kfwd ? kstep[i-4] : wkey_q[i-4]);
        end
    end

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    always_comb begin
        hready_d = HREADYOUT;
        rd_pend_d = 1'b0;
        wr_pend_d = 1'b0;
        addr_d = addr_q;
        hrdata_d = HRDATA;
        if (rd_pend_q) begin
            hready_d = 1'b1;
            hrdata_d = 32'h0000_0000;
            if (map_hit) begin
                case (addr_q[3:2])
                    REG_CTRL[3:2]: begin
                        hrdata_d[CTRL_DEC] = dec_q;
                        hrdata_d[CTRL_AUTO] = auto_q;
                        hrdata_d[CTRL_XOR] = xor_q;
                        hrdata_d[CTRL_IRQEN] = irqen_q;
                    end
                    REG_STATUS[3:2]: begin
                        hrdata_d[STAT_DONE] = done_q;
                        hrdata_d[STAT_BUSY] = busy;
                    end
                    REG_STATE[3:2]: hrdata_d[7:0] = st_q[sidx_q];
                    default: hrdata_d[7:0] = key_q[kidx_q];
                endcase
            end
        end
        if (take) begin
            addr_d = HADDR[7:0];
            wr_pend_d = HWRITE;
            rd_pend_d = !HWRITE;
            hready_d = HWRITE;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            HREADYOUT <= 1'b1;
            HRDATA <= 32'h0000_0000;
            HRESP <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q <= RST_BYTE;
        end else begin
            HREADYOUT <= hready_d;
            HRDATA <= hrdata_d;
            HRESP <= 1'b0;
            rd_pend_q <= rd_pend_d;
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
        end
    end

    // ---------------------------------------------------------------
    // memories, control and sequencer
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        key_d = key_q;
        wst_d = wst_q;
        wkey_d = wkey_q;
        sidx_d = sidx_q;
        kidx_d = kidx_q;
        dec_d = dec_q;
        auto_d = auto_q;
        xor_d = xor_q;
        irqen_d = irqen_q;
        done_d = done_q;
        opdec_d = opdec_q;
        fsm_d = fsm_q;
        cyc_d = busy ? cyc_q + 9'h001 : cyc_q;
        span_d = busy ? span_q + 9'h001 : 9'h000; // length of the busy run, checked below
        rnd_d = rnd_q;
        rcon_d = rcon_q;
        start = 1'b0;
        finish = busy && (cyc_q == OP_LAST);
        if (wr_pend_q && map_hit) begin
            case (addr_q[3:2])
                REG_CTRL[3:2]: begin
                    dec_d = HWDATA[CTRL_DEC];
                    auto_d = HWDATA[CTRL_AUTO];
                    xor_d = HWDATA[CTRL_XOR];
                    irqen_d = HWDATA[CTRL_IRQEN];
                    sidx_d = 4'h0;
                    kidx_d = 4'h0;
                    start = HWDATA[CTRL_START];
                end
                REG_STATUS[3:2]: begin
                    if (HWDATA[STAT_DONE]) begin
                        done_d = 1'b0;
                    end
                end
                REG_STATE[3:2]: begin
                    if (!busy) begin
                        st_d[sidx_q] = xor_q ? (st_q[sidx_q] ^ HWDATA[7:0]) : HWDATA[7:0];
                        sidx_d = sidx_q + 4'h1;
                        start = auto_q && (sidx_q == 4'hf);
                    end
                end
                default: begin
                    if (!busy) begin
                        key_d[kidx_q] = HWDATA[7:0];
                        kidx_d = kidx_q + 4'h1;
                    end
                end
            endcase
        end
        if (rd_pend_q && map_hit && !busy) begin
            if (addr_q[3:2] == REG_STATE[3:2]) begin
                sidx_d = sidx_q + 4'h1;
            end else if (addr_q[3:2] == REG_KEY[3:2]) begin
                kidx_d = kidx_q + 4'h1;
            end
        end
        case (fsm_q)
            S_IDLE: begin
                if (start) begin
                    fsm_d = dec_d ? S_PREP : S_WHITE;
                    opdec_d = dec_d;
                    wst_d = st_d;
                    wkey_d = key_d;
                    rcon_d = RCON_INIT;
                    cyc_d = 9'h000;
                    rnd_d = 4'h0;
                    sidx_d = 4'h0;
                    kidx_d = 4'h0;
                end
            end
            S_PREP: begin
                // decryption walks the key forward to the last round key first
                wkey_d = kstep;
                rcon_d = abc_xt(rcon_q);
                rnd_d = last ? 4'h0 : rnd_q + 4'h1;
                fsm_d = last ? S_WHITE : S_PREP;
            end
            S_WHITE: begin
                wst_d = wst_q ^ wkey_q;
                fsm_d = S_ROUND;
            end
            S_ROUND: begin
                wst_d = rres;
                wkey_d = kstep;
                rcon_d = kfwd ? abc_xt(rcon_q) : rcon_prev;
                rnd_d = rnd_q + 4'h1;
                fsm_d = last ? S_HOLD : S_ROUND;
            end
            S_HOLD: fsm_d = S_HOLD;
            default: fsm_d = S_IDLE;
        endcase
        if (finish) begin
            st_d = wst_q;
            done_d = 1'b1; // set wins over a same-cycle clear
            fsm_d = S_IDLE;
            sidx_d = 4'h0;
            kidx_d = 4'h0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '0;
            key_q <= '0;
            wst_q <= '0;
            wkey_q <= '0;
            sidx_q <= 4'h0;
            kidx_q <= 4'h0;
            dec_q <= RST_CTRL_BIT;
            auto_q <= RST_CTRL_BIT;
            xor_q <= RST_CTRL_BIT;
            irqen_q <= RST_CTRL_BIT;
            done_q <= 1'b0;
            opdec_q <= 1'b0;
            fsm_q <= S_IDLE;
            cyc_q <= 9'h000;
            span_q <= 9'h000;
            rnd_q <= 4'h0;
            rcon_q <= RCON_INIT;
            IRQ <= 1'b0;
            DMA_TRIG <= 1'b0;
        end else begin
            st_q <= st_d;
            key_q <= key_d;
            wst_q <= wst_d;
            wkey_q <= wkey_d;
            sidx_q <= sidx_d;
            kidx_q <= kidx_d;
            dec_q <= dec_d;
            auto_q <= auto_d;
            xor_q <= xor_d;
            irqen_q <= irqen_d;
            done_q <= done_d;
            opdec_q <= opdec_d;
            fsm_q <= fsm_d;
            cyc_q <= cyc_d;
            span_q <= span_d;
            rnd_q <= rnd_d;
            rcon_q <= rcon_d;
            IRQ <= done_d && irqen_d;
            DMA_TRIG <= finish;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    chk_done_time: assert property ($rose(done_q) |-> $past(busy) && $past(cyc_q) == OP_LAST)
        else $error("done flag rose at the wrong cycle");
    chk_busy_span: assert property ($fell(busy) |-> $past(span_q) == OP_LAST)
        else $error("operation did not last 375 cycles");
    chk_state_held: assert property (busy && cyc_q != OP_LAST |=> $stable(st_q))
        else $error("state memory changed during an operation");
    chk_irq_raise: assert property ($rose(done_q) && irqen_q |-> IRQ)
        else $error("enabled completion gave no interrupt");
    chk_irq_quiet: assert property (!irqen_q |=> !IRQ || $past(irqen_d))
        else $error("interrupt raised while disabled");
    chk_dma_pulse: assert property (DMA_TRIG |-> done_q && !busy ##1 !DMA_TRIG)
        else $error("dma trigger not a single completion pulse");
    chk_auto_begin: assert property (wr_pend_q && addr_q == REG_STATE && !busy && auto_q
            && sidx_q == 4'hf |=> busy && sidx_q == 4'h0)
        else $error("auto-start missed after last state byte");
    chk_xor_load: assert property (wr_pend_q && addr_q == REG_STATE && !busy && xor_q
            |=> st_q[$past(sidx_q)] == $past(st_q[sidx_q] ^ HWDATA[7:0]))
        else $error("xor load did not combine with held byte");
    chk_key_index: assert property (wr_pend_q && addr_q == REG_KEY && !busy
            |=> kidx_q == $past(kidx_q) + 4'h1)
        else $error("key index did not advance");
    chk_round_count: assert property (fsm_q == S_ROUND && last |=> fsm_q == S_HOLD)
        else $error("round sequence did not end after ten rounds");

endmodule

`default_nettype wire

// >>> abc_host_model.sv
// ahb-lite host model: single word transfers towards the cipher block
`default_nettype none

module abc_host_model (
    // clock
    input wire logic clk,
    // ahb-lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // ---------------------------------------------------------------
    // bus phases
    // ---------------------------------------------------------------
    // address phase held until hready; stale write data is inverted
    task automatic addr_ph(input logic [31:0] a, input logic w);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hwdata <= ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        haddr <= ~a;
    endtask

    // write: address phase, then write data held until hready
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        addr_ph(a, 1'b1);
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        addr_ph(a, 1'b0);
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask
endmodule

`default_nettype wire

// >>> aes_block_crypto_module_tb_top.sv
// self-checking bench for the block cipher module with a reference model
`default_nettype none

module aes_block_crypto_module_tb_top
    import abc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic CLOCK;
    logic RSTN = 1'b0;
    logic HSEL;
    logic [31:0] HADDR;
    logic [1:0] HTRANS;
    logic HWRITE;
    logic [2:0] HSIZE;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic IRQ;
    logic DMA_TRIG;
    int sb[256];
    int ks[176];
    int st[16];
    int key[16];
    int pt[16];
    int ct[16];
    int cyc = 0;
    int trig_cyc = 0;
    int trig_n = 0;
    int t0 = 0;
    int bad_count = 0;
    int cmp_count = 0;
    logic trig_irq = 1'b0;

    abc_host_model i_abc_host_model (.clk(CLOCK), .hsel(HSEL), .haddr(HADDR),
        .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE), .hwdata(HWDATA),
        .hready(HREADYOUT), .hrdata(HRDATA));

    abc_top i_abc_top (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .IRQ(IRQ), .DMA_TRIG(DMA_TRIG));

    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    // cycle count and record of each trigger cycle
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (DMA_TRIG === 1'b1) begin
            trig_cyc <= cyc;
            trig_irq <= IRQ;
            trig_n <= trig_n + 1;
        end
    end

    // ---------------------------------------------------------------
    // reference model
    // ---------------------------------------------------------------
    function automatic int xt(input int a);
        return ((a << 1) & 8'hff) ^ ((a & 8'h80) != 0 ? int'(GF_POLY) : 0);
    endfunction

    function automatic int gmul(input int a, input int b);
        int p;
        p = 0;
        for (int i = 0; i < 8; i++) begin
            if (((b >> i) & 1) != 0) p = p ^ a;
            a = xt(a);
        end
        return p;
    endfunction

    task automatic aes_enc();
        int t[16];
        int rc;
        int x;
        rc = 1;
        for (int i = 0; i < 16; i++) ks[i] = key[i];
        for (int i = 16; i < 176; i += 4) begin
            for (int j = 0; j < 4; j++) t[j] = ks[i - 4 + j];
            if (i % 16 == 0) begin
                x = t[0];
                t[0] = sb[t[1]] ^ rc;
                t[1] = sb[t[2]];
                t[2] = sb[t[3]];
                t[3] = sb[x];
                rc = xt(rc);
            end
            for (int j = 0; j < 4; j++) ks[i + j] = ks[i - 16 + j] ^ t[j];
        end
        for (int i = 0; i < 16; i++) st[i] = st[i] ^ ks[i];
        for (int r = 1; r <= 10; r++) begin
            for (int i = 0; i < 16; i++) t[i] = sb[st[i]];
            for (int i = 0; i < 16; i++) st[i] = t[(i + 4 * (i % 4)) % 16];
            for (int c = 0; c < 4 && r < 10; c++) begin
                for (int j = 0; j < 4; j++) t[j] = st[4 * c + j];
                for (int j = 0; j < 4; j++)
                    st[4 * c + j] = xt(t[j]) ^ xt(t[(j + 1) % 4]) ^ t[(j + 1) % 4]
                        ^ t[(j + 2) % 4] ^ t[(j + 3) % 4];
            end
            for (int i = 0; i < 16; i++) st[i] = st[i] ^ ks[16 * r + i];
        end
    endtask

    // ---------------------------------------------------------------
    // checks and bus helpers
    // ---------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_data(input string w, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_time(input string w, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            bad_count++;
            $display("MISMATCH %s expected %0d seen %0d", w, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_abc_host_model.bus_wr({24'h0, a}, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] v;
        i_abc_host_model.bus_rd({24'h0, a}, v);
        chk_data(w, e, v);
    endtask

    task automatic load(input logic [7:0] a, input int b[16]);
        for (int i = 0; i < 16; i++) wr(a, 32'(b[i] & 8'hff));
    endtask

    task automatic wait_trig(input int n);
        for (int i = 0; i < 1000; i++) begin
            if (trig_n >= n) break;
            @(posedge CLOCK);
        end
        chk_time("trigger count", n, trig_n);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int msk[16];
        int tmp[16];
        int inv;
        int s;
        int r;
        void'($urandom(99));
        for (int v = 0; v < 256; v++) begin
            inv = 0;
            for (int y = 1; y < 256; y++) if (gmul(v, y) == 1) inv = y;
            s = inv;
            r = inv;
            for (int k = 0; k < 4; k++) begin
                r = ((r << 1) | (r >> 7)) & 8'hff;
                s = s ^ r;
            end
            sb[v] = s ^ int'(SBOX_AFF_C);
        end
        for (int i = 0; i < 16; i++) begin
            key[i] = $urandom & 8'hff;
            pt[i] = $urandom & 8'hff;
            msk[i] = $urandom & 8'hff;
            tmp[i] = pt[i] ^ msk[i];
        end
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        @(posedge CLOCK);
        rd_chk(REG_CTRL, 32'h0, "ctrl reset");
        rd_chk(REG_STATUS, 32'h0, "status reset");
        wr(8'h40, 32'hffffffff);
        rd_chk(8'h40, 32'h0, "unmapped");
        // encrypt, state built by plain load then xor load
        wr(REG_CTRL, 32'h10);
        load(REG_KEY, key);
        load(REG_STATE, msk);
        wr(REG_CTRL, 32'h18);
        rd_chk(REG_CTRL, 32'h18, "ctrl readback");
        load(REG_STATE, tmp);
        wr(REG_CTRL, 32'h11);
        t0 = cyc;
        rd_chk(REG_STATUS, 32'h2, "busy");
        wr(REG_STATE, 32'h5a);
        wr(REG_CTRL, 32'h11);
        st = pt;
        aes_enc();
        ct = st;
        wait_trig(1);
        chk_time("enc latency", OP_CYCLES + 1, trig_cyc - t0);
        chk_data("irq at done", 32'h1, 32'(trig_irq));
        rd_chk(REG_STATUS, 32'h1, "done");
        for (int i = 0; i < 16; i++) rd_chk(REG_STATE, 32'(ct[i]), "cipher");
        chk_time("trig pulses", 1, trig_n);
        wr(REG_STATUS, 32'h1);
        rd_chk(REG_STATUS, 32'h0, "done clear");
        chk_data("irq cleared", 32'h0, 32'(IRQ));
        // decrypt by auto-start with the interrupt disabled
        wr(REG_CTRL, 32'h6);
        load(REG_STATE, ct);
        t0 = cyc;
        wait_trig(2);
        chk_time("dec latency", OP_CYCLES + 1, trig_cyc - t0);
        chk_data("irq masked", 32'h0, 32'(trig_irq));
        for (int i = 0; i < 16; i++) rd_chk(REG_STATE, 32'(pt[i]), "plain");
        // key memory keeps the cipher key through both operations
        for (int i = 0; i < 16; i++) rd_chk(REG_KEY, 32'(key[i]), "key kept");
        chk_data("hresp okay", 32'h0, 32'(HRESP));
        final_report();
    end

    // watchdog: the sequence needs about 1100 cycles
    initial begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule

`default_nettype wire
